// ==== logic/lane_ctrl_pkg.sv ====
// Constants and carrier types for the redriver lane control register bank
package lane_ctrl_pkg;

  // ==========================================================
  // Register offsets (one-byte sub-address space)
  localparam logic [7:0] GENERAL_CONTROL_ADDR = 8'h0A;
  localparam logic [7:0] LANE01_EQ_SELECT_ADDR = 8'h10;
  localparam logic [7:0] LANE23_EQ_SELECT_ADDR = 8'h11;
  localparam logic [7:0] SNOOPED_LINK_STATUS_ADDR = 8'h12;
  localparam logic [7:0] LANE_MONITOR_CONTROL_ADDR = 8'h13;

  // ==========================================================
  // Field positions
  localparam int HOTPLUG_PIN_SWAP_BIT = 5;
  localparam int EQ_REGISTER_SELECT_BIT = 4;
  localparam int HOTPLUG_FORCE_HIGH_BIT = 3;
  localparam int LINK_CONTROL_UPPER_BIT = 1;
  localparam int MONITOR_DISABLE_BIT = 7;
  localparam int POWER_STATE_LSB = 5;
  localparam int LANE_COUNT_LSB = 0;
  localparam int LANES = 4;
  localparam int EQ_W = 4;

  // ==========================================================
  // Reset values and encodings
  localparam logic [1:0] LINK_SHUTDOWN = 2'h0;
  localparam logic [1:0] LINK_IDLE = 2'h1;
  localparam logic [1:0] LINK_ENABLED = 2'h2;
  localparam logic [1:0] LINK_CONTROL_RESET = LINK_IDLE;
  localparam logic [3:0] EQ_RESET = 4'h0;
  localparam logic [1:0] POWER_STATE_RESET = 2'h0;
  localparam logic [4:0] LANE_COUNT_RESET = 5'h00;
  localparam logic [1:0] POWER_STATE_ACTIVE = 2'h1;
  localparam logic [4:0] LANE_COUNT_ONE = 5'h01;
  localparam logic [4:0] LANE_COUNT_TWO = 5'h02;
  localparam logic [4:0] LANE_COUNT_FOUR = 5'h04;
  localparam logic [3:0] MASK_ONE = 4'h1;
  localparam logic [3:0] MASK_TWO = 4'h3;
  localparam logic [3:0] MASK_FOUR = 4'hF;
  localparam logic [3:0] MASK_NONE = 4'h0;

  // ==========================================================
  // Snooped AUX locations
  localparam logic [19:0] AUX_POWER_STATE_LOC = 20'h00600;
  localparam logic [19:0] AUX_LANE_COUNT_LOC = 20'h00101;

  // ==========================================================
  // Serial port and timing
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h44;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [19:0] addr;
    logic [7:0] data;
  } aux_capture_t;

  typedef struct packed {
    logic [LANES-1:0] enable;
    logic [LANES*EQ_W-1:0] eq;
  } lane_ctrl_t;

endpackage : lane_ctrl_pkg

// ==== logic/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;

  // ==========================================================
  // Next value: a bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_reg <= INIT;
    end else begin
      s1_reg <= D;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign Q = q_reg;
endmodule // pin_sync
`default_nettype wire

// ==== logic/redriver_lane_control_regs.sv ====
// Lane control register bank with two-wire serial target
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Swap bit exchanges the hotplug input pins
// - Override bit picks straps or lane fields
// - Force bit holds hotplug state high
// - Link control field, resets to idle
// - Four 4-bit lane equalization fields, reset zero
// - Without override, fields mirror strap level
// - With override, software writes set equalization
// - Power state captured from AUX, read-only
// - Monitoring on: power state gates lanes
// - Lane count captured from AUX, read-only
// - Monitoring on: lane count picks lanes
// - Monitoring off: lane off bits rule power
// - Monitoring off: lane count ignored
// - Upper link bit falling clears power state
// - Upper link bit falling clears lane count
// - Monitor disable bit, resets to enabled
// - Lane off bits act only unmonitored
// - Address, sub-address, auto-increment data bytes
module redriver_lane_control_regs
  import lane_ctrl_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic HOTPLUG_PIN_A,
  input wire logic HOTPLUG_PIN_B,
  input wire logic [3:0] EQ_STRAP_PINS,
  input wire aux_capture_t AUX_CAPTURE,
  output logic HOTPLUG_STATE,
  output logic LINK_SHUTDOWN_N,
  output lane_ctrl_t LANE_CTRL
);

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_ADDR_ACK = 9'h004,
    S_SUB = 9'h008,
    S_SUB_ACK = 9'h010,
    S_WDATA = 9'h020,
    S_WDATA_ACK = 9'h040,
    S_RDATA = 9'h080,
    S_RACK = 9'h100
  } i2c_state_t;

  // ==========================================================
  // Pin synchronisers
  logic scl_f, sda_f, hp_a_f, hp_b_f;
  logic [3:0] strap_f;

  pin_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .REF_CLK(REF_CLK),
    .RESET_N(RESET_N),
    .D({SCL_IN, SDA_IN}),
    .Q({scl_f, sda_f})
  );

  pin_sync #(.W(6), .INIT(6'h00)) u_pin_sync (
    .REF_CLK(REF_CLK),
    .RESET_N(RESET_N),
    .D({HOTPLUG_PIN_A, HOTPLUG_PIN_B, EQ_STRAP_PINS}),
    .Q({hp_a_f, hp_b_f, strap_f})
  );

  // ==========================================================
  // Bus edge detection
  logic scl_prev_reg, sda_prev_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
    end
  end

  always_comb begin
    scl_rise = scl_f & ~scl_prev_reg;
    scl_fall = ~scl_f & scl_prev_reg;
    start_cond = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
    stop_cond = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;
  end

  // ==========================================================
  // Register state
  logic swap_reg, swap_next, eqsel_reg, eqsel_next, force_reg, force_next;
  logic [1:0] ctl_reg, ctl_next;
  logic ctl_up_prev_reg;
  logic [LANES*EQ_W-1:0] eq_reg, eq_next;
  logic [1:0] pwr_reg, pwr_next;
  logic [4:0] lcnt_reg, lcnt_next;
  logic mon_off_reg, mon_off_next;
  logic [LANES-1:0] lane_off_reg, lane_off_next;
  logic [3:0] strap_level_reg, strap_level_next;
  logic [2:0] strap_cnt_reg, strap_cnt_next;
  logic strap_done_reg, strap_done_next;

  // ==========================================================
  // Serial target state
  i2c_state_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
  logic [2:0] cnt_reg, cnt_next;
  logic done_reg, done_next, rw_reg, rw_next, mack_reg, mack_next;
  logic oe_reg, oe_next;
  logic wr_strobe;
  logic [7:0] rd_data;

  // Read mux; unmapped offsets and reserved bits return zero
  always_comb begin
    rd_data = 8'h00;
    case (ptr_reg)
      GENERAL_CONTROL_ADDR: begin
        rd_data[HOTPLUG_PIN_SWAP_BIT] = swap_reg;
        rd_data[EQ_REGISTER_SELECT_BIT] = eqsel_reg;
        rd_data[HOTPLUG_FORCE_HIGH_BIT] = force_reg;
        rd_data[LINK_CONTROL_UPPER_BIT:0] = ctl_reg;
      end
      LANE01_EQ_SELECT_ADDR: rd_data = eq_reg[2*EQ_W-1:0];
      LANE23_EQ_SELECT_ADDR: rd_data = eq_reg[4*EQ_W-1:2*EQ_W];
      SNOOPED_LINK_STATUS_ADDR: begin
        rd_data[POWER_STATE_LSB+1:POWER_STATE_LSB] = pwr_reg;
        rd_data[LANE_COUNT_LSB+4:LANE_COUNT_LSB] = lcnt_reg;
      end
      LANE_MONITOR_CONTROL_ADDR: begin
        rd_data[MONITOR_DISABLE_BIT] = mon_off_reg;
        rd_data[LANES-1:0] = lane_off_reg;
      end
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    rw_next = rw_reg;
    mack_next = mack_reg;
    oe_next = oe_reg;
    wr_strobe = 1'b0;
    if (start_cond) begin
      st_next = S_ADDR;
      cnt_next = 3'h0;
      done_next = 1'b0;
      oe_next = 1'b0;
    end else if (stop_cond) begin
      st_next = S_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        S_IDLE: st_next = S_IDLE;
        S_ADDR, S_SUB, S_WDATA: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_f};
            cnt_next = cnt_reg + 3'h1;
            done_next = (cnt_reg == BIT_LAST);
          end else if (scl_fall && done_reg) begin
            done_next = 1'b0;
            oe_next = 1'b1;
            if (st_reg == S_ADDR) begin
              rw_next = sh_reg[0];
              if (sh_reg[7:1] == TARGET_ADDR) begin
                st_next = S_ADDR_ACK;
              end else begin
                st_next = S_IDLE;
                oe_next = 1'b0;
              end
            end else if (st_reg == S_SUB) begin
              ptr_next = sh_reg;
              st_next = S_SUB_ACK;
            end else begin
              // Successive bytes land in successive offsets
              wr_strobe = 1'b1;
              ptr_next = ptr_reg + 8'h01;
              st_next = S_WDATA_ACK;
            end
          end
        end
        S_ADDR_ACK, S_SUB_ACK, S_WDATA_ACK: begin
          if (scl_fall) begin
            cnt_next = 3'h0;
            if (st_reg == S_ADDR_ACK && rw_reg) begin
              sh_next = rd_data;
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~rd_data[7];
              st_next = S_RDATA;
            end else begin
              oe_next = 1'b0;
              st_next = (st_reg == S_ADDR_ACK) ? S_SUB : S_WDATA;
            end
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 3'h1;
            done_next = (cnt_reg == BIT_LAST);
          end else if (scl_fall) begin
            if (done_reg) begin
              done_next = 1'b0;
              oe_next = 1'b0;
              st_next = S_RACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_next = ~sda_f;
          end else if (scl_fall) begin
            cnt_next = 3'h0;
            if (mack_reg) begin
              sh_next = rd_data;
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~rd_data[7];
              st_next = S_RDATA;
            end else begin
              st_next = S_IDLE;
            end
          end
        end
        default: begin
          st_next = S_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= S_IDLE;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      cnt_reg <= 3'h0;
      done_reg <= 1'b0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      rw_reg <= rw_next;
      mack_reg <= mack_next;
      oe_reg <= oe_next;
    end
  end

  // ==========================================================
  // Strap capture after reset release; pins must settle first
  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    strap_level_next = strap_level_reg;
    if (!strap_done_reg) begin
      strap_cnt_next = strap_cnt_reg + 3'h1;
      if (strap_cnt_reg == STRAP_SETTLE_CYCLES) begin
        strap_level_next = strap_f;
        strap_done_next = 1'b1;
      end
    end
  end

  // ==========================================================
  // Control registers and snoop capture
  logic ctl_fall, wr_gen, wr_mon;

  always_comb begin
    wr_gen = wr_strobe && (ptr_reg == GENERAL_CONTROL_ADDR);
    wr_mon = wr_strobe && (ptr_reg == LANE_MONITOR_CONTROL_ADDR);
    ctl_fall = ctl_up_prev_reg & ~ctl_reg[LINK_CONTROL_UPPER_BIT];
    swap_next = swap_reg;
    eqsel_next = eqsel_reg;
    force_next = force_reg;
    ctl_next = ctl_reg;
    mon_off_next = mon_off_reg;
    lane_off_next = lane_off_reg;
    pwr_next = pwr_reg;
    lcnt_next = lcnt_reg;
    if (wr_gen) begin
      swap_next = sh_reg[HOTPLUG_PIN_SWAP_BIT];
      eqsel_next = sh_reg[EQ_REGISTER_SELECT_BIT];
      force_next = sh_reg[HOTPLUG_FORCE_HIGH_BIT];
      ctl_next = sh_reg[LINK_CONTROL_UPPER_BIT:0];
    end
    if (wr_mon) begin
      mon_off_next = sh_reg[MONITOR_DISABLE_BIT];
      lane_off_next = sh_reg[LANES-1:0];
    end
    // clear on upper bit fall; a capture in the same cycle wins
    if (ctl_fall) begin
      pwr_next = POWER_STATE_RESET;
      lcnt_next = LANE_COUNT_RESET;
    end
    if (AUX_CAPTURE.valid && AUX_CAPTURE.addr == AUX_POWER_STATE_LOC) begin
      pwr_next = AUX_CAPTURE.data[1:0];
    end
    if (AUX_CAPTURE.valid && AUX_CAPTURE.addr == AUX_LANE_COUNT_LOC) begin
      lcnt_next = AUX_CAPTURE.data[4:0];
    end
  end

  // ==========================================================
  // Per-lane equalization and power
  logic [LANES-1:0] snoop_mask, lane_on;

  always_comb begin
    case (lcnt_reg)
      LANE_COUNT_ONE: snoop_mask = MASK_ONE;
      LANE_COUNT_TWO: snoop_mask = MASK_TWO;
      LANE_COUNT_FOUR: snoop_mask = MASK_FOUR;
      default: snoop_mask = MASK_NONE;
    endcase
    if (pwr_reg != POWER_STATE_ACTIVE) begin
      snoop_mask = MASK_NONE;
    end
  end

  genvar ln;
  generate
    for (ln = 0; ln < LANES; ln++) begin : g_lane
      localparam logic [7:0] LANE_ADDR = (ln < 2) ? LANE01_EQ_SELECT_ADDR : LANE23_EQ_SELECT_ADDR;
      localparam int NIB = (ln % 2) * EQ_W;
      always_comb begin
        eq_next[ln*EQ_W +: EQ_W] = eq_reg[ln*EQ_W +: EQ_W];
        if (!eqsel_reg) begin
          eq_next[ln*EQ_W +: EQ_W] = strap_level_reg;
        end else if (wr_strobe && ptr_reg == LANE_ADDR) begin
          eq_next[ln*EQ_W +: EQ_W] = sh_reg[NIB +: EQ_W];
        end
        lane_on[ln] = mon_off_reg ? ~lane_off_reg[ln] : snoop_mask[ln];
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      swap_reg <= 1'b0;
      eqsel_reg <= 1'b0;
      force_reg <= 1'b0;
      ctl_reg <= LINK_CONTROL_RESET;
      ctl_up_prev_reg <= LINK_CONTROL_RESET[LINK_CONTROL_UPPER_BIT];
      mon_off_reg <= 1'b0;
      lane_off_reg <= '0;
      pwr_reg <= POWER_STATE_RESET;
      lcnt_reg <= LANE_COUNT_RESET;
      eq_reg <= {LANES{EQ_RESET}};
      strap_level_reg <= EQ_RESET;
      strap_cnt_reg <= 3'h0;
      strap_done_reg <= 1'b0;
    end else begin
      swap_reg <= swap_next;
      eqsel_reg <= eqsel_next;
      force_reg <= force_next;
      ctl_reg <= ctl_next;
      ctl_up_prev_reg <= ctl_reg[LINK_CONTROL_UPPER_BIT];
      mon_off_reg <= mon_off_next;
      lane_off_reg <= lane_off_next;
      pwr_reg <= pwr_next;
      lcnt_reg <= lcnt_next;
      eq_reg <= eq_next;
      strap_level_reg <= strap_level_next;
      strap_cnt_reg <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // ==========================================================
  // Outputs; lanes stay dark unless the link is enabled
  logic hp_next, hp_reg, shut_n_reg;
  lane_ctrl_t lane_ctrl_reg, lane_ctrl_next;

  always_comb begin
    hp_next = force_reg | (swap_reg ? hp_b_f : hp_a_f);
    lane_ctrl_next.eq = eq_reg;
    lane_ctrl_next.enable = (ctl_reg == LINK_ENABLED) ? lane_on : '0;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hp_reg <= 1'b0;
      shut_n_reg <= 1'b1;
      lane_ctrl_reg <= '0;
    end else begin
      hp_reg <= hp_next;
      shut_n_reg <= (ctl_reg != LINK_SHUTDOWN);
      lane_ctrl_reg <= lane_ctrl_next;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_reg;
  assign HOTPLUG_STATE = hp_reg;
  assign LINK_SHUTDOWN_N = shut_n_reg;
  assign LANE_CTRL = lane_ctrl_reg;
endmodule // redriver_lane_control_regs
`default_nettype wire

// ==== verif/lane_ctrl_props.sv ====
// Port-level assertions for the lane control register bank
`timescale 1ns/10ps
`default_nettype none
module lane_ctrl_props
  import lane_ctrl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic HOTPLUG_PIN_A,
  input wire logic HOTPLUG_PIN_B,
  input wire aux_capture_t AUX_CAPTURE,
  input wire logic HOTPLUG_STATE,
  input wire logic LINK_SHUTDOWN_N,
  input wire lane_ctrl_t LANE_CTRL
);
  // ==========================================================
  // Age since reset; strap capture moves eq early on
  logic [3:0] age_reg;
  logic [3:0] age_next;
  always_comb begin
    age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      age_reg <= 4'h0;
    end else begin
      age_reg <= age_next;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================================
  // Properties
  property p_reset_vals;
    $rose(RESET_N) |-> LINK_SHUTDOWN_N && !SDA_OE && !HOTPLUG_STATE && LANE_CTRL == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs off reset values");
  property p_open_drain;
    SDA_OE |-> !SDA_OUT;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_oe_scl_low;
    $changed(SDA_OE) |-> !SCL_IN;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive moved with clock high");
  property p_oe_stands;
    $rose(SDA_OE) |-> SDA_OE [*6];
  endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("data drive too short");
  property p_link_write;
    $changed(LINK_SHUTDOWN_N) |-> !SCL_IN;
  endproperty
  a_link_write: assert property (p_link_write) else $error("shutdown moved outside a write");
  // Both outputs register the same link field, so they move together
  property p_off_no_lanes;
    !LINK_SHUTDOWN_N |-> LANE_CTRL.enable == 4'h0;
  endproperty
  a_off_no_lanes: assert property (p_off_no_lanes) else $error("lanes on in shutdown");
  property p_hotplug_high;
    (HOTPLUG_PIN_A && HOTPLUG_PIN_B) [*8] |-> HOTPLUG_STATE;
  endproperty
  a_hotplug_high: assert property (p_hotplug_high) else $error("hotplug low with both pins high");
  property p_en_cause;
    $changed(LANE_CTRL.enable) |-> !SCL_IN || $past(AUX_CAPTURE.valid, 2) || $past(AUX_CAPTURE.valid, 3);
  endproperty
  a_en_cause: assert property (p_en_cause) else $error("lane enable moved without cause");
  property p_eq_cause;
    $changed(LANE_CTRL.eq) |-> !SCL_IN || age_reg < 4'hC;
  endproperty
  a_eq_cause: assert property (p_eq_cause) else $error("eq moved without cause");
  c_ack: cover property ($rose(SDA_OE));
  c_all_lanes: cover property (LANE_CTRL.enable == 4'hF);
  c_shutdown: cover property ($fell(LINK_SHUTDOWN_N));
endmodule // lane_ctrl_props
bind redriver_lane_control_regs lane_ctrl_props u_props (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .HOTPLUG_PIN_A(HOTPLUG_PIN_A), .HOTPLUG_PIN_B(HOTPLUG_PIN_B),
  .AUX_CAPTURE(AUX_CAPTURE), .HOTPLUG_STATE(HOTPLUG_STATE), .LINK_SHUTDOWN_N(LINK_SHUTDOWN_N), .LANE_CTRL(LANE_CTRL));
`default_nettype wire

// ==== verif/test_redriver_lane_control_regs.sv ====
// Self-checking testbench for the lane control register bank
`timescale 1ns/10ps
`default_nettype none
module test_redriver_lane_control_regs
  import lane_ctrl_pkg::*;
;
  logic REF_CLK;
  logic RESET_N;
  logic hp_a;
  logic hp_b;
  logic [3:0] straps;
  aux_capture_t aux_in;
  wire scl;
  wire sda_low;
  wire sda_line;
  logic sda_out;
  logic sda_oe;
  logic hp_state;
  logic shut_n;
  lane_ctrl_t lanes;
  int fail_count = 0;
  int num_checks = 0;
  // Pull-up on the shared data line
  assign sda_line = !(sda_low || (sda_oe && !sda_out));
  redriver_lane_control_regs DUT (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .HOTPLUG_PIN_A(hp_a), .HOTPLUG_PIN_B(hp_b), .EQ_STRAP_PINS(straps),
    .AUX_CAPTURE(aux_in), .HOTPLUG_STATE(hp_state), .LINK_SHUTDOWN_N(shut_n), .LANE_CTRL(lanes));
  twowire_host_model host (.REF_CLK(REF_CLK), .SDA_LINE(sda_line), .SCL(scl), .SDA_LOW(sda_low));
  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] sub, input logic [7:0] exp);
    logic [7:0] q;
    host.rd(sub, q);
    chk($sformatf("reg %h", sub), {8'h00, exp}, {8'h00, q});
  endtask
  task automatic aux(input logic [19:0] a, input logic [7:0] d);
    aux_in = '{valid: 1'b1, addr: a, data: d};
    cyc(1);
    aux_in = '0;
    cyc(3);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    chk("shutdown_n", 16'h0001, {15'h0, shut_n});
    rchk(GENERAL_CONTROL_ADDR, 8'h01);
    rchk(LANE01_EQ_SELECT_ADDR, 8'h66);
    rchk(LANE23_EQ_SELECT_ADDR, 8'h66);
    rchk(SNOOPED_LINK_STATUS_ADDR, 8'h00);
    rchk(LANE_MONITOR_CONTROL_ADDR, 8'h00);
    chk("lane eq", 16'h6666, lanes.eq);
  endtask
  task automatic t_snoop();
    logic [4:0] cnt [4] = '{5'h01, 5'h02, 5'h04, 5'h03};
    logic [3:0] msk [4] = '{4'h1, 4'h3, 4'hF, 4'h0};
    host.wr(GENERAL_CONTROL_ADDR, 8'h02, 8'h00, 1'b0);
    aux(AUX_POWER_STATE_LOC, 8'h01);
    for (int i = 0; i < 4; i++) begin
      aux(AUX_LANE_COUNT_LOC, {3'h0, cnt[i]});
      chk("lane enable", {12'h0, msk[i]}, {12'h0, lanes.enable});
    end
    aux(20'h00602, 8'h1F);
    rchk(SNOOPED_LINK_STATUS_ADDR, 8'h23);
    aux(AUX_LANE_COUNT_LOC, 8'h04);
    aux(AUX_POWER_STATE_LOC, 8'h02);
    chk("lane enable", 16'h0000, {12'h0, lanes.enable});
    host.wr(GENERAL_CONTROL_ADDR, 8'h00, 8'h00, 1'b0);
    rchk(SNOOPED_LINK_STATUS_ADDR, 8'h00);
    chk("shutdown_n", 16'h0000, {15'h0, shut_n});
  endtask
  task automatic t_monitor_off();
    host.wr(GENERAL_CONTROL_ADDR, 8'h02, 8'h00, 1'b0);
    aux(AUX_LANE_COUNT_LOC, 8'h01);
    aux(AUX_POWER_STATE_LOC, 8'h02);
    host.wr(LANE_MONITOR_CONTROL_ADDR, 8'hF5, 8'h00, 1'b0);
    chk("lane enable", 16'h000A, {12'h0, lanes.enable});
    rchk(LANE_MONITOR_CONTROL_ADDR, 8'h85);
    // Active state with count one would show as lane 0 alone if the count leaked
    aux(AUX_POWER_STATE_LOC, 8'h01);
    host.wr(LANE_MONITOR_CONTROL_ADDR, 8'h80, 8'h00, 1'b0);
    chk("lane enable", 16'h000F, {12'h0, lanes.enable});
  endtask
  task automatic t_eq();
    host.wr(LANE01_EQ_SELECT_ADDR, 8'h5A, 8'hC3, 1'b1);
    rchk(LANE01_EQ_SELECT_ADDR, 8'h66);
    host.wr(GENERAL_CONTROL_ADDR, 8'h12, 8'h00, 1'b0);
    host.wr(LANE01_EQ_SELECT_ADDR, 8'h21, 8'h43, 1'b1);
    chk("lane eq", 16'h4321, lanes.eq);
    rchk(LANE23_EQ_SELECT_ADDR, 8'h43);
    host.wr(GENERAL_CONTROL_ADDR, 8'h02, 8'h00, 1'b0);
    chk("lane eq", 16'h6666, lanes.eq);
  endtask
  task automatic t_hotplug();
    logic [10:0] rows [7] = '{{8'h02, 3'b101}, {8'h02, 3'b010}, {8'h22, 3'b011}, {8'h22, 3'b100},
      {8'h0A, 3'b001}, {8'h02, 3'b111}, {8'h02, 3'b000}};
    for (int i = 0; i < 7; i++) begin
      host.wr(GENERAL_CONTROL_ADDR, rows[i][10:3], 8'h00, 1'b0);
      hp_a = rows[i][2];
      hp_b = rows[i][1];
      cyc(10);
      chk("hotplug", {15'h0, rows[i][0]}, {15'h0, hp_state});
    end
  endtask
  task automatic t_refused();
    logic ack;
    host.start_cond();
    host.send_byte({TARGET_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
    host.stop_cond();
    chk("foreign ack", 16'h0000, {15'h0, ack});
    host.wr(GENERAL_CONTROL_ADDR, 8'hFF, 8'h00, 1'b0);
    rchk(GENERAL_CONTROL_ADDR, 8'h3B);
    // Reserved link code 11 is not enabled, so every lane goes dark
    chk("lane enable", 16'h0000, {12'h0, lanes.enable});
    host.wr(SNOOPED_LINK_STATUS_ADDR, 8'h00, 8'h00, 1'b0);
    rchk(SNOOPED_LINK_STATUS_ADDR, 8'h21);
    rchk(8'h20, 8'h00);
    chk("nack count", 16'h0001, host.nacks[15:0]);
  endtask
  // ==========================================================
  // Clock, reset and sequence
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  initial begin
    repeat (100000) @(posedge REF_CLK);
    fail_count++;
    give_verdict();
  end
  initial begin
    RESET_N = 1'b0;
    hp_a = 1'b0;
    hp_b = 1'b0;
    straps = 4'h6;
    aux_in = '0;
    cyc(10);
    RESET_N = 1'b1;
    cyc(20);
    t_reset_values();
    t_snoop();
    t_monitor_off();
    t_eq();
    t_hotplug();
    t_refused();
    give_verdict();
  end
endmodule // test_redriver_lane_control_regs
`default_nettype wire

// ==== verif/twowire_host_model.sv ====
// Two-wire host controller model for the register port
`timescale 1ns/10ps
`default_nettype none
module twowire_host_model
  import lane_ctrl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SDA_LINE,
  output logic SCL,
  output logic SDA_LOW
);
  int nacks;
  initial begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
    nacks = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  // Data moves only with clock low
  task automatic bit_io(input logic b, output logic s);
    SDA_LOW = !b;
    tick(3);
    SCL = 1'b1;
    tick(4);
    s = SDA_LINE;
    tick(4);
    SCL = 1'b0;
    tick(8);
  endtask
  task automatic start_cond();
    SDA_LOW = 1'b0;
    tick(3);
    SCL = 1'b1;
    tick(8);
    SDA_LOW = 1'b1;
    tick(8);
    SCL = 1'b0;
    tick(8);
  endtask
  task automatic stop_cond();
    SDA_LOW = 1'b1;
    tick(3);
    SCL = 1'b1;
    tick(8);
    SDA_LOW = 1'b0;
    tick(8);
  endtask
  // Byte out MSB first, then target acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
    if (!ack) nacks++;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
    bit_io(last, s);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1, input logic two);
    logic a;
    start_cond();
    send_byte({TARGET_ADDR_DEFAULT, 1'b0}, a);
    send_byte(sub, a);
    send_byte(d0, a);
    if (two) send_byte(d1, a);
    stop_cond();
  endtask
  task automatic rd(input logic [7:0] sub, output logic [7:0] q);
    logic a;
    start_cond();
    send_byte({TARGET_ADDR_DEFAULT, 1'b0}, a);
    send_byte(sub, a);
    start_cond();
    send_byte({TARGET_ADDR_DEFAULT, 1'b1}, a);
    recv_byte(1'b1, q);
    stop_cond();
  endtask
endmodule // twowire_host_model
`default_nettype wire
